/* File: bench/dpm_ctrl_asserts.sv */
// Checker of the positioning control block ports.
`timescale 1ns/1ns
`default_nettype none
module dpm_ctrl_asserts
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic runCmd,
   input wire logic moveDone,
   input wire logic pulseTrain,
   input wire logic [31:0] cmdPosIn,
   input wire logic [31:0] ffIn,
   input wire logic [31:0] targetPos_q,
   input wire logic moveStart_q,
   input wire logic complete_q,
   input wire logic irq_q,
   input wire logic [31:0] filtCmdPos,
   input wire logic [31:0] filtFf
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_busAnswer;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_busAnswer: assert property (p_busAnswer) else $error("bus answer late");
   property p_ffBypass;
      !pulseTrain |=> filtFf == $past(ffIn);
   endproperty
   a_ffBypass: assert property (p_ffBypass) else $error("ff filtered");
   property p_cmdBypass;
      !pulseTrain |=> filtCmdPos == $past(cmdPosIn);
   endproperty
   a_cmdBypass: assert property (p_cmdBypass) else $error("cmd filtered");
   property p_doneCause;
      $rose(complete_q) |-> $past(moveDone) && $past(runCmd);
   endproperty
   a_doneCause: assert property (p_doneCause) else $error("stray done");
   property p_runClears;
      !runCmd |=> !complete_q;
   endproperty
   a_runClears: assert property (p_runClears) else $error("done kept");
   property p_startPulse;
      moveStart_q |=> !moveStart_q [*8];
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("bad start");
   property p_tgtOnStart;
      $changed(targetPos_q) |-> moveStart_q;
   endproperty
   a_tgtOnStart: assert property (p_tgtOnStart) else $error("tgt moved");
   property p_startRun;
      moveStart_q |-> $past(runCmd);
   endproperty
   a_startRun: assert property (p_startRun) else $error("start idle");
   c_start: cover property (moveStart_q);
   c_done: cover property ($rose(complete_q));
   c_irq: cover property (irq_q);
endmodule // dpm_ctrl_asserts
bind dpm_position_ctrl dpm_ctrl_asserts dpm_ctrl_asserts_inst (.clk(clk),
   .rst_b(rst_b), .read(read), .write(write), .waitrequest(waitrequest),
   .runCmd(runCmd), .moveDone(moveDone), .pulseTrain(pulseTrain),
   .cmdPosIn(cmdPosIn), .ffIn(ffIn), .targetPos_q(targetPos_q),
   .moveStart_q(moveStart_q), .complete_q(complete_q), .irq_q(irq_q),
   .filtCmdPos(filtCmdPos), .filtFf(filtFf));
`default_nettype wire

/* File: bench/dpm_far_side.sv */
// Model of the run source, enabling terminal and regulator.
`timescale 1ns/1ns
`default_nettype none
module dpm_far_side
(
   input wire logic clk,
   input wire logic moveStart_q,
   output logic runCmd,
   output logic posEnable,
   output logic moveDone
);
   logic [4:0] travel;
   logic slow;
   initial
   begin
      runCmd = 1'b0;
      posEnable = 1'b0;
      moveDone = 1'b0;
      travel = 5'h00;
      slow = 1'b0;
   end
   // Regulator reports arrival after a short or a long travel.
   always @(posedge clk)
   begin
      moveDone <= (travel == 5'h01);
      if (moveStart_q === 1'b1)
      begin
         travel <= slow ? 5'h14 : 5'h02;
         slow <= !slow;
      end
      else if (travel != 5'h00)
         travel <= travel - 5'h01;
   end
   task automatic setRun(input logic v);
      @(posedge clk);
      runCmd <= v;
   endtask
   task automatic setEn(input logic v);
      @(posedge clk);
      posEnable <= v;
   endtask
endmodule // dpm_far_side
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench of the positioning control block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rstB = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteEn = 4'hF;
   logic [31:0] readdata, targetPos_q, filtCmdPos, filtFf;
   logic waitrequest, runCmd, posEnable, moveDone;
   logic moveStart_q, complete_q, irq_q;
   logic pulseTrain = 1'b0;
   logic [31:0] cmdPosIn = 32'h0;
   logic [31:0] ffIn = 32'h0;
   logic [31:0] seed = 32'h48FE;
   logic [31:0] rd, expTgt, step, sp;
   logic [31:0] rv [0:6] = '{32'h1E, 32'h0, 32'h0, 32'h0, 32'hA, 32'h3E8,
      32'h3E8};
   int nFail = 0;
   int samplesChecked = 0;
   int starts;
   int highCyc;
   always #5 clk = !clk;
   dpm_position_ctrl #(.TICK_CYCLES(10)) dpm_position_ctrl_inst (.clk(clk),
      .rst_b(rstB), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteEn), .readdata(readdata),
      .waitrequest(waitrequest), .posEnable(posEnable), .runCmd(runCmd),
      .moveDone(moveDone), .pulseTrain(pulseTrain), .cmdPosIn(cmdPosIn),
      .ffIn(ffIn), .targetPos_q(targetPos_q), .moveStart_q(moveStart_q),
      .complete_q(complete_q), .irq_q(irq_q), .filtCmdPos(filtCmdPos),
      .filtFf(filtFf));
   dpm_far_side far_inst (.clk(clk), .moveStart_q(moveStart_q),
      .runCmd(runCmd), .posEnable(posEnable), .moveDone(moveDone));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [31:0] scaled(input logic [31:0] v);
      return (v * 32'h3) / 32'h2;
   endfunction
   // Random references reach the filters every cycle.
   always @(posedge clk)
   begin
      seed <= xs(seed);
      cmdPosIn <= seed;
      ffIn <= {seed[15:0], seed[31:16]};
      pulseTrain <= seed[3];
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         nFail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      chk(32'(n), 32'h2);
   endtask
   task automatic watch(input int cyc, input logic recip, input logic pulse);
      logic prevC;
      prevC = 1'b0;
      repeat (cyc)
      begin
         @(posedge clk);
         if (moveStart_q === 1'b1)
         begin
            expTgt = (recip && starts[0]) ? expTgt - step :
               expTgt + step;
            chk(targetPos_q, expTgt);
            starts++;
         end
         if (pulse && prevC)
            chk(32'(complete_q), 32'h0);
         if (complete_q === 1'b1)
            highCyc++;
         prevC = complete_q;
      end
   endtask
   task automatic setup(input logic [15:0] mode, input logic [15:0] hold);
      far_inst.setRun(1'b0);
      @(posedge clk);
      rstB <= 1'b0;
      repeat (12) @(posedge clk);
      rstB <= 1'b1;
      sp = {23'h0, seed[8:0]} + 32'h1;
      step = scaled(sp);
      expTgt = 32'h0;
      starts = 0;
      acc(1'b1, 4'h5, 32'h3);
      acc(1'b1, 4'h6, 32'h2);
      acc(1'b1, 4'h3, sp);
      acc(1'b1, 4'h9, 32'h1);
      acc(1'b1, 4'h4, {16'h0, hold});
      acc(1'b1, 4'h2, {16'h0, mode});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      nFail++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rstB <= 1'b1;
      foreach (rv[i])
      begin
         acc(1'b0, 4'(i), 32'h0);
         chk(rd, rv[i]);
      end
      acc(1'b0, 4'hB, 32'h0);
      chk(rd, 32'h0);
      acc(1'b1, 4'h5, 32'h0);
      acc(1'b0, 4'h5, 32'h0);
      chk(rd, 32'h3E8);
      acc(1'b1, 4'h2, 32'hFFFF0031);
      acc(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h31);
      byteEn <= 4'h2;
      acc(1'b1, 4'h2, 32'h0000AB5A);
      byteEn <= 4'hF;
      acc(1'b0, 4'h2, 32'h0);
      chk(rd, 32'hAB31);
      setup(16'h00C0, 16'h000A);
      far_inst.setRun(1'b1);
      watch(80, 1'b0, 1'b0);
      chk(32'(starts), 32'h1);
      chk(32'(complete_q), 32'h1);
      chk(32'(irq_q), 32'h1);
      acc(1'b1, 4'h8, 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(irq_q), 32'h0);
      starts = 0;
      far_inst.setEn(1'b1);
      watch(150, 1'b0, 1'b0);
      chk(32'(starts), 32'h1);
      far_inst.setEn(1'b0);
      acc(1'b1, 4'h2, 32'h1C4);
      starts = 0;
      far_inst.setEn(1'b1);
      watch(200, 1'b0, 1'b0);
      chk(32'(starts > 2), 32'h1);
      far_inst.setEn(1'b0);
      watch(80, 1'b0, 1'b0);
      setup(16'h0006, 16'h0000);
      far_inst.setRun(1'b1);
      watch(300, 1'b1, 1'b1);
      chk(32'(starts > 3), 32'h1);
      setup(16'h0000, 16'h0002);
      far_inst.setRun(1'b1);
      watch(60, 1'b0, 1'b0);
      chk(32'(starts), 32'h0);
      highCyc = 0;
      far_inst.setEn(1'b1);
      watch(400, 1'b0, 1'b0);
      chk(32'(starts), 32'h1);
      chk(32'(highCyc >= 100 && highCyc <= 201), 32'h1);
      far_inst.setEn(1'b0);
      setup(16'h00CE, 16'h0000);
      far_inst.setRun(1'b1);
      watch(120, 1'b0, 1'b0);
      chk(32'(starts), 32'h1);
      sp = {24'h0, seed[7:0]} + 32'h200;
      step = scaled(sp);
      expTgt = 32'h0;
      acc(1'b1, 4'h3, sp);
      watch(120, 1'b0, 1'b0);
      chk(32'(starts), 32'h2);
      conclude();
   end
endmodule // testbench
`default_nettype wire

/* File: logic/dpm_gear_scale.v */
// Sequential scaler: setpoint times numerator over denominator.
`timescale 1ns/1ns
`default_nettype none
module dpm_gear_scale
(
   input wire clk,
   input wire rst_b,
   input wire start,
   input wire [15:0] setpoint,
   input wire [15:0] numerator,
   input wire [15:0] denominator,
   output reg [31:0] result_q,
   output reg done_q
);
   reg [31:0] dividend_q;
   reg [16:0] remain_q;
   reg [5:0] count_q;
   reg busy_q;
   wire [16:0] trial;
   wire fits;
   assign trial = {remain_q[15:0], dividend_q[31]};
   assign fits = trial >= {1'b0, denominator};
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         result_q <= 32'h00000000;
         done_q <= 1'b0;
         dividend_q <= 32'h00000000;
         remain_q <= 17'h00000;
         count_q <= 6'h00;
         busy_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (start)
         begin
            dividend_q <= setpoint * numerator;
            remain_q <= 17'h00000;
            count_q <= 6'h20;
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            remain_q <= fits ? trial - {1'b0, denominator} : trial;
            dividend_q <= {dividend_q[30:0], fits};
            count_q <= count_q - 6'h01;
            if (count_q == 6'h01)
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               result_q <= {dividend_q[30:0], fits};
            end
         end
      end
   end
endmodule // dpm_gear_scale
`default_nettype wire

/* File: logic/dpm_lag_filter.v */
// First-order lag filter stepped on a 0.1 ms tick.
`timescale 1ns/1ns
`default_nettype none
module dpm_lag_filter
(
   input wire clk,
   input wire rst_b,
   input wire tick,
   input wire active,
   input wire [15:0] timeConst,
   input wire [31:0] x,
   output reg [31:0] y_q
);
   wire signed [32:0] diff;
   wire signed [32:0] tcWide;
   wire signed [32:0] step;
   assign diff = $signed({x[31], x}) - $signed({y_q[31], y_q});
   assign tcWide = $signed({17'h00000, timeConst});
   assign step = (timeConst == 16'h0000) ? diff : diff / tcWide;
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         y_q <= 32'h00000000;
      end
      else if (!active || timeConst == 16'h0000)
      begin
         y_q <= x;
      end
      else if (tick)
      begin
         y_q <= y_q + step[31:0];
      end
   end
endmodule // dpm_lag_filter
`default_nettype wire

/* File: logic/dpm_position_ctrl.v */
// Digital positioning mode control with Avalon-MM register slave.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dpm_regs.vh"
module dpm_position_ctrl
#(
   parameter TICK_CYCLES = `DPM_TICK_CYCLES
)
(
   input wire clk,
   input wire rst_b,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire posEnable,
   input wire runCmd,
   input wire moveDone,
   input wire pulseTrain,
   input wire [31:0] cmdPosIn,
   input wire [31:0] ffIn,
   output reg [31:0] targetPos_q,
   output reg moveStart_q,
   output reg complete_q,
   output reg irq_q,
   output wire [31:0] filtCmdPos,
   output wire [31:0] filtFf
);
   reg [15:0] ffTime_q;
   reg [15:0] cmdTime_q;
   reg [15:0] modeWord_q;
   reg [15:0] setpoint_q;
   reg [15:0] holdTime_q;
   reg [15:0] gearNum_q;
   reg [15:0] gearDen_q;
   reg [`DPM_IRQ_WIDTH-1:0] irqStat_q;
   reg [`DPM_IRQ_WIDTH-1:0] irqMask_q;
   reg [15:0] modeLat_q;
   reg [15:0] spLast_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg enPrev_q;
   reg edgeSeen_q;
   reg reverse_q;
   reg [15:0] holdCnt_q;
   reg [15:0] tickCnt_q;
   reg [3:0] msCnt_q;
   reg tick_q;
   reg msTick_q;
   reg [31:0] rdMux;
   wire busReq;
   wire busAccept;
   wire wrAccept;
   wire [31:0] beMask;
   wire [31:0] wrLow;
   wire autoMode;
   wire recip;
   wire posType;
   wire termOk;
   wire spChanged;
   wire go;
   wire gearDone;
   wire [31:0] gearResult;
   wire holdExpired;
   wire [`DPM_IRQ_WIDTH-1:0] irqEvents;
   wire [`DPM_IRQ_WIDTH-1:0] irqClear;

   assign busReq = read | write;
   assign busAccept = busReq & waitrequest;
   assign wrAccept = write & ~waitrequest;
   assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

   function [15:0] merge16;
      input [15:0] oldVal;
      input [31:0] newVal;
      input [31:0] mask;
      begin
         merge16 = (oldVal & ~mask[15:0]) | (newVal[15:0] & mask[15:0]);
      end
   endfunction

   assign wrLow = writedata & beMask;

   // Bus slave: one wait cycle, then the access completes.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end
      else
      begin
         waitrequest <= ~busAccept;
         if (busAccept && read)
         begin
            readdata <= rdMux;
         end
      end
   end

   always @*
   begin
      rdMux = 32'h00000000;
      case (address)
         `DPM_ADDR_FF_TIME: rdMux = {16'h0000, ffTime_q};
         `DPM_ADDR_CMD_TIME: rdMux = {16'h0000, cmdTime_q};
         `DPM_ADDR_MODE: rdMux = {16'h0000, modeWord_q};
         `DPM_ADDR_SETPOINT: rdMux = {16'h0000, setpoint_q};
         `DPM_ADDR_HOLD_TIME: rdMux = {16'h0000, holdTime_q};
         `DPM_ADDR_GEAR_NUM: rdMux = {16'h0000, gearNum_q};
         `DPM_ADDR_GEAR_DEN: rdMux = {16'h0000, gearDen_q};
         `DPM_ADDR_STATE: rdMux = {25'h0000000, reverse_q, complete_q,
                                   state_q, moveStart_q};
         `DPM_ADDR_IRQ_STAT: rdMux = {30'h00000000, irqStat_q};
         `DPM_ADDR_IRQ_MASK: rdMux = {30'h00000000, irqMask_q};
         `DPM_ADDR_TARGET: rdMux = targetPos_q;
         default: rdMux = 32'h00000000;
      endcase
   end

   // Register writes; a zero gear denominator is refused.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ffTime_q <= `DPM_RST_FF_TIME;
         cmdTime_q <= `DPM_RST_CMD_TIME;
         modeWord_q <= `DPM_RST_MODE;
         setpoint_q <= `DPM_RST_SETPOINT;
         holdTime_q <= `DPM_RST_HOLD_TIME;
         gearNum_q <= `DPM_RST_GEAR_NUM;
         gearDen_q <= `DPM_RST_GEAR_DEN;
         irqMask_q <= {`DPM_IRQ_WIDTH{1'b0}};
      end
      else if (wrAccept)
      begin
         case (address)
            `DPM_ADDR_FF_TIME:
               ffTime_q <= merge16(ffTime_q, writedata, beMask);
            `DPM_ADDR_CMD_TIME:
               cmdTime_q <= merge16(cmdTime_q, writedata, beMask);
            `DPM_ADDR_MODE:
               modeWord_q <= merge16(modeWord_q, writedata, beMask);
            `DPM_ADDR_SETPOINT:
               setpoint_q <= merge16(setpoint_q, writedata, beMask);
            `DPM_ADDR_HOLD_TIME:
               holdTime_q <= merge16(holdTime_q, writedata, beMask);
            `DPM_ADDR_GEAR_NUM:
               if (merge16(gearNum_q, writedata, beMask) != 16'h0000)
               begin
                  gearNum_q <= merge16(gearNum_q, writedata, beMask);
               end
            `DPM_ADDR_GEAR_DEN:
               if (merge16(gearDen_q, writedata, beMask) != 16'h0000)
               begin
                  gearDen_q <= merge16(gearDen_q, writedata, beMask);
               end
            `DPM_ADDR_IRQ_MASK: irqMask_q <= wrLow[`DPM_IRQ_WIDTH-1:0];
            default: irqMask_q <= irqMask_q;
         endcase
      end
   end

   // Time base: a 0.1 ms tick and a 1 ms tick.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tickCnt_q <= 16'h0000;
         msCnt_q <= 4'h0;
         tick_q <= 1'b0;
         msTick_q <= 1'b0;
      end
      else
      begin
         tick_q <= 1'b0;
         msTick_q <= 1'b0;
         if (tickCnt_q == TICK_CYCLES[15:0] - 16'h0001)
         begin
            tickCnt_q <= 16'h0000;
            tick_q <= 1'b1;
            if (msCnt_q == `DPM_TICKS_PER_MS - 4'h1)
            begin
               msCnt_q <= 4'h0;
               msTick_q <= 1'b1;
            end
            else
            begin
               msCnt_q <= msCnt_q + 4'h1;
            end
         end
         else
         begin
            tickCnt_q <= tickCnt_q + 16'h0001;
         end
      end
   end

   dpm_lag_filter uFfFilter
   (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick_q),
      .active(pulseTrain),
      .timeConst(ffTime_q),
      .x(ffIn),
      .y_q(filtFf)
   );

   dpm_lag_filter uCmdFilter
   (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick_q),
      .active(pulseTrain),
      .timeConst(cmdTime_q),
      .x(cmdPosIn),
      .y_q(filtCmdPos)
   );

   dpm_gear_scale uGear
   (
      .clk(clk),
      .rst_b(rst_b),
      .start(go),
      .setpoint(setpoint_q),
      .numerator(gearNum_q),
      .denominator(gearDen_q),
      .result_q(gearResult),
      .done_q(gearDone)
   );

   // Trigger qualification uses the live mode word before a move.
   assign autoMode = modeWord_q[`DPM_BIT_AUTO];
   assign recip = modeWord_q[`DPM_BIT_RECIP] & autoMode;
   assign posType = modeWord_q[`DPM_BIT_POSTYPE] & recip;
   assign termOk = modeWord_q[`DPM_BIT_EN_LEVEL] ? posEnable :
                   edgeSeen_q;
   assign spChanged = setpoint_q != spLast_q;
   assign go = runCmd & (
      (state_q == `DPM_ST_IDLE &&
         (modeWord_q[`DPM_BIT_FIRST_RUN] | autoMode | termOk)) ||
      (state_q == `DPM_ST_DONE &&
         (posType ? spChanged : (autoMode | termOk))));
   assign holdExpired = holdCnt_q == 16'h0000;

   always @*
   begin
      state_d = state_q;
      case (state_q)
         `DPM_ST_IDLE: if (go) state_d = `DPM_ST_CALC;
         `DPM_ST_CALC: if (gearDone) state_d = `DPM_ST_MOVE;
         `DPM_ST_MOVE: if (moveDone) state_d = `DPM_ST_DONE;
         `DPM_ST_DONE: if (go) state_d = `DPM_ST_CALC;
         default: state_d = `DPM_ST_IDLE;
      endcase
      if (!runCmd)
      begin
         state_d = `DPM_ST_IDLE;
      end
   end

   // Move sequencer, target arithmetic and completion output.
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= `DPM_ST_IDLE;
         modeLat_q <= `DPM_RST_MODE;
         spLast_q <= `DPM_RST_SETPOINT;
         enPrev_q <= 1'b0;
         edgeSeen_q <= 1'b0;
         reverse_q <= 1'b0;
         holdCnt_q <= 16'h0000;
         targetPos_q <= 32'h00000000;
         moveStart_q <= 1'b0;
         complete_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         enPrev_q <= posEnable;
         moveStart_q <= 1'b0;
         if (go)
         begin
            modeLat_q <= modeWord_q;
            spLast_q <= setpoint_q;
            complete_q <= 1'b0;
         end
         if (posEnable && !enPrev_q &&
             (state_q == `DPM_ST_IDLE || state_q == `DPM_ST_DONE))
         begin
            edgeSeen_q <= 1'b1;
         end
         else if (go)
         begin
            edgeSeen_q <= 1'b0;
         end
         if (state_q == `DPM_ST_CALC && gearDone && runCmd)
         begin
            moveStart_q <= 1'b1;
            if (modeLat_q[`DPM_BIT_POSTYPE] && modeLat_q[`DPM_BIT_RECIP] &&
                modeLat_q[`DPM_BIT_AUTO])
            begin
               targetPos_q <= gearResult;
            end
            else if (reverse_q)
            begin
               targetPos_q <= targetPos_q - gearResult;
            end
            else
            begin
               targetPos_q <= targetPos_q + gearResult;
            end
            if (modeLat_q[`DPM_BIT_RECIP] && modeLat_q[`DPM_BIT_AUTO] &&
                !modeLat_q[`DPM_BIT_POSTYPE])
            begin
               reverse_q <= ~reverse_q;
            end
         end
         if (state_q == `DPM_ST_MOVE && moveDone && runCmd)
         begin
            complete_q <= 1'b1;
            holdCnt_q <= holdTime_q;
         end
         else if (!runCmd)
         begin
            complete_q <= 1'b0;
         end
         else if (complete_q && !modeLat_q[`DPM_BIT_DONE_LEVEL])
         begin
            if (holdExpired)
            begin
               complete_q <= 1'b0;
            end
            else if (msTick_q)
            begin
               holdCnt_q <= holdCnt_q - 16'h0001;
            end
         end
      end
   end

   // Interrupt status: events set, a written one clears, set wins.
   assign irqEvents[`DPM_IRQ_DONE] = state_q == `DPM_ST_MOVE && moveDone &&
                                     runCmd;
   assign irqEvents[`DPM_IRQ_START] = state_q == `DPM_ST_CALC && gearDone &&
                                      runCmd;
   assign irqClear = (wrAccept && address == `DPM_ADDR_IRQ_STAT) ?
                     wrLow[`DPM_IRQ_WIDTH-1:0] : {`DPM_IRQ_WIDTH{1'b0}};

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irqStat_q <= {`DPM_IRQ_WIDTH{1'b0}};
         irq_q <= 1'b0;
      end
      else
      begin
         irqStat_q <= (irqStat_q & ~irqClear) | irqEvents;
         irq_q <= |(((irqStat_q & ~irqClear) | irqEvents) & irqMask_q);
      end
   end
endmodule // dpm_position_ctrl
`default_nettype wire

/* File: logic/dpm_regs.vh */
// Constants of the digital positioning mode control block.
`ifndef DPM_REGS_VH
`define DPM_REGS_VH
`define DPM_CLK_PERIOD_NS 10
`define DPM_TICK_NS 100000
`define DPM_TICK_CYCLES (`DPM_TICK_NS / `DPM_CLK_PERIOD_NS)
`define DPM_TICKS_PER_MS 4'hA
`define DPM_ADDR_FF_TIME 4'h0
`define DPM_ADDR_CMD_TIME 4'h1
`define DPM_ADDR_MODE 4'h2
`define DPM_ADDR_SETPOINT 4'h3
`define DPM_ADDR_HOLD_TIME 4'h4
`define DPM_ADDR_GEAR_NUM 4'h5
`define DPM_ADDR_GEAR_DEN 4'h6
`define DPM_ADDR_STATE 4'h7
`define DPM_ADDR_IRQ_STAT 4'h8
`define DPM_ADDR_IRQ_MASK 4'h9
`define DPM_ADDR_TARGET 4'hA
`define DPM_RST_FF_TIME 16'h001E
`define DPM_RST_CMD_TIME 16'h0000
`define DPM_RST_MODE 16'h0000
`define DPM_RST_SETPOINT 16'h0000
`define DPM_RST_HOLD_TIME 16'h000A
`define DPM_RST_GEAR_NUM 16'h03E8
`define DPM_RST_GEAR_DEN 16'h03E8
`define DPM_BIT_ABSOLUTE 0
`define DPM_BIT_AUTO 1
`define DPM_BIT_RECIP 2
`define DPM_BIT_POSTYPE 3
`define DPM_BIT_ORG_EVERY 4
`define DPM_BIT_ORG_ONCE_CAL 5
`define DPM_BIT_DONE_LEVEL 6
`define DPM_BIT_FIRST_RUN 7
`define DPM_BIT_EN_LEVEL 8
`define DPM_IRQ_DONE 0
`define DPM_IRQ_START 1
`define DPM_IRQ_WIDTH 2
`define DPM_ST_IDLE 4'h1
`define DPM_ST_CALC 4'h2
`define DPM_ST_MOVE 4'h4
`define DPM_ST_DONE 4'h8
`endif
